/* File: verilog/ofm_cfg.svh */
// Constants for the output fault monitor: timing, widths and word slots.
// Assumes a 125 MHz mclk; included by the package and the block.
`ifndef OFM_CFG_SVH
`define OFM_CFG_SVH
`define OFM_CLK_MHZ 125
`define OFM_PULSE_US 500
`define OFM_PERIOD_MS 1000
`define OFM_SETTLE_CYC 64
`define OFM_POINTS 16
`define OFM_GROUP_SIZE 8
`define OFM_WORD_CMD 1'b0
`define OFM_WORD_UNUSED 1'b1
`define OFM_BIT_SHORT_BASE 6'h10
`define OFM_RST_WORD 16'h0000
`define OFM_RST_SW 2'h0
`endif

/* File: verilog/ofm_pkg.sv */
// Types shared by the output fault monitor and its surroundings.
// Assumes ofm_cfg.svh is on the include path.
`include "ofm_cfg.svh"
package ofm_pkg;
  // Pulse-test phase of the once-per-period sequence
  typedef enum logic [0:0] {
    PH_RUN = 1'b0,
    PH_PULSE = 1'b1
  } phase_t;

  // Controller request on the backplane I/O bus
  typedef struct packed {
    logic wr_word;
    logic word_sel;
    logic [15:0] wdata;
    logic wr_bit;
    logic [4:0] bit_addr;
    logic bit_val;
    logic [5:0] rd_bit_addr;
  } io_req_t;

  // Answer to the controller
  typedef struct packed {
    logic [15:0] open_word;
    logic [15:0] short_word;
    logic rd_bit;
  } io_rsp_t;

  // Field sensing per point, from the output stage
  typedef struct packed {
    logic [1:0] pulse_sw;
    logic [15:0] short_det;
    logic [15:0] open_det;
  } field_in_t;
endpackage

/* File: verilog/output_fault_monitor.sv */
// Sixteen-point discrete output block with open and short fault monitoring.
// Assumes field sense lines and the group switches are asynchronous pins,
// and the controller bus is synchronous to mclk.
// Operation
// RULE1: Full mode pulses each output inverse for 500 us once per second.
// RULE2: Partial mode finds opens only when off, shorts only when on.
// RULE3: Full mode finds opens and shorts at either commanded level.
// RULE4: Block appears as four 16-bit words or 32 bit outputs and inputs.
// RULE5: Command word bit per point sets each point's commanded level.
// RULE6: Open on point n sets bit n of the open fault word.
// RULE7: Short on point n sets bit n of the short fault word.
// RULE8: Status bit one means fault, zero means normal operation.
// RULE9: Second command word is ignored; writes to it change nothing.
// RULE10: A detected short forces that output off in either mode.
// RULE11: Full mode turns an open point off; partial mode leaves it.
// RULE12: Outside pulse mode a command to the opposite level clears faults.
// RULE13: Partial mode: writing one clears the point's open indication.
// RULE14: Partial mode: writing zero clears the point's short indication.
// RULE15: Full mode controller clears a fault by fixing it, then writing zero.
// RULE16: Group lamp blinks while any point of the group holds a fault.
// RULE17: Mapping picks bits or words; output format picks binary or BCD.
// RULE18: Per-group switch enables full pulse testing for its eight points.
// RULE19: In word formats point 16 is bit 0 of word one; word two ignored.
// RULE20: Faults stay latched until cleared; a test pulse is never a fault.
`timescale 1ns/10ps
`default_nettype none
`include "ofm_cfg.svh"

module output_fault_monitor #(
  parameter int PULSE_CYC = `OFM_PULSE_US * `OFM_CLK_MHZ,
  parameter int PERIOD_CYC = `OFM_PERIOD_MS * 1000 * `OFM_CLK_MHZ,
  parameter int SETTLE_CYC = `OFM_SETTLE_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Configuration from the controller setup
  input wire logic map_word,
  input wire logic fmt_bcd,
  // Controller bus
  input wire ofm_pkg::io_req_t req,
  output ofm_pkg::io_rsp_t rsp,
  // Field side
  input wire ofm_pkg::field_in_t field,
  output logic [15:0] pt_out,
  output logic [1:0] lamp
);
  import ofm_pkg::*;

  localparam int NP = `OFM_POINTS;
  localparam int NG = NP / `OFM_GROUP_SIZE;
  localparam int NS = $bits(field_in_t);

  // Whole block state
  typedef struct packed {
    logic [NS-1:0] s1;
    logic [NS-1:0] s2;
    logic [NS-1:0] s3;
    logic [NS-1:0] filt;
    logic [15:0] cmd;
    logic [15:0] open_f;
    logic [15:0] short_f;
    logic [15:0] drive;
    logic [31:0] per;
    logic [15:0] stab;
    phase_t phase;
    logic blink;
    logic rd_bit;
  } state_t;

  state_t st_q;
  state_t st_d;

  // Four BCD digits to a binary point pattern
  function automatic logic [15:0] bcd_to_bin(input logic [15:0] w);
    logic [15:0] r;
    r = 16'({12'h000, w[15:12]} * 16'd1000);
    r = 16'(r + 16'({12'h000, w[11:8]} * 16'd100));
    r = 16'(r + 16'({12'h000, w[7:4]} * 16'd10));
    r = 16'(r + {12'h000, w[3:0]});
    return r;
  endfunction

  // Decoded views of the filtered field inputs and the controller bus requests
  field_in_t fin;
  logic [15:0] full_pt;
  logic [15:0] new_cmd;
  logic [15:0] wr_mask;
  logic [15:0] forced;
  logic [15:0] open_hit;
  logic [15:0] short_hit;
  logic [15:0] open_clr;
  logic [15:0] short_clr;
  logic valid;
  logic word_wr;
  logic [15:0] wr_val;
  logic [15:0] drive_nx;
  logic [15:0] det_ok;

  assign fin = field_in_t'(st_q.filt);
  assign valid = (st_q.stab == 16'(SETTLE_CYC));
  // Only the first command word reaches the points
  assign word_wr = req.wr_word && map_word && (req.word_sel == `OFM_WORD_CMD); // RULE9

  // Word data as a point pattern, converted from four digits in BCD format
  always_comb begin
    wr_val = req.wdata;
    if (fmt_bcd) begin
      wr_val = bcd_to_bin(req.wdata); // RULE17
    end
  end

  // Next drive: command, inverted in full groups while pulsing, forced off on a short or on an open in a full group
  always_comb begin
    drive_nx = st_q.cmd & ~forced; // RULE10 RULE11
    if (st_q.phase == PH_PULSE) begin
      drive_nx = (st_q.cmd ^ full_pt) & ~forced; // RULE1
    end
  end

  // Detection only on a steady point
  // A written point or one whose drive is about to move is not sensed,
  // so a clearing write is never undone by the level it is leaving.
  always_comb begin
    det_ok = ~wr_mask;
    if (!valid) begin
      det_ok = 16'h0000;
    end
    det_ok = det_ok & ~(drive_nx ^ st_q.drive); // RULE13 RULE14
  end

  // Per point: group mode, write data, detection and clearing
  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_pt
      // Point 16 sits in word bit 0, point 1 in bit 15
      localparam int PNUM = NP - gi; // RULE19
      assign full_pt[gi] = fin.pulse_sw[gi / `OFM_GROUP_SIZE]; // RULE18
      always_comb begin
        wr_mask[gi] = 1'b0;
        new_cmd[gi] = st_q.cmd[gi];
        if (word_wr) begin
          wr_mask[gi] = 1'b1;
          new_cmd[gi] = wr_val[gi]; // RULE5
        end else if (req.wr_bit && !map_word && (req.bit_addr == 5'(PNUM - 1))) begin
          wr_mask[gi] = 1'b1; // RULE4
          new_cmd[gi] = req.bit_val;
        end
      end
      // Shorts always force off; opens only in full mode
      assign forced[gi] = st_q.short_f[gi] || (full_pt[gi] && st_q.open_f[gi]); // RULE10 RULE11
      // Detection only once the drive has settled, so a pulse edge never trips
      always_comb begin
        if (full_pt[gi]) begin
          open_hit[gi] = det_ok[gi] && fin.open_det[gi]; // RULE3 RULE20
          short_hit[gi] = det_ok[gi] && fin.short_det[gi]; // RULE3
        end else begin
          open_hit[gi] = det_ok[gi] && fin.open_det[gi] && !st_q.drive[gi]; // RULE2
          short_hit[gi] = det_ok[gi] && fin.short_det[gi] && st_q.drive[gi]; // RULE2
        end
      end
      // Clearing by command write
      always_comb begin
        open_clr[gi] = 1'b0;
        short_clr[gi] = 1'b0;
        if (wr_mask[gi]) begin
          if (full_pt[gi]) begin
            open_clr[gi] = !new_cmd[gi]; // RULE15
            short_clr[gi] = !new_cmd[gi]; // RULE15
          end else begin
            open_clr[gi] = new_cmd[gi]; // RULE13 RULE12
            short_clr[gi] = !new_cmd[gi]; // RULE14 RULE12
          end
        end
      end
    end
  endgenerate

  // Next state
  always_comb begin
    st_d = st_q;
    // Three-stage pin synchroniser, change accepted when stages 2 and 3 agree
    st_d.s1 = NS'(field);
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    st_d.filt = (st_q.s2 & ~(st_q.s2 ^ st_q.s3)) | (st_q.filt & (st_q.s2 ^ st_q.s3));
    st_d.cmd = new_cmd; // RULE5
    // Set wins over clear; bits stay latched otherwise
    st_d.open_f = (st_q.open_f & ~open_clr) | open_hit; // RULE6 RULE8 RULE20
    st_d.short_f = (st_q.short_f & ~short_clr) | short_hit; // RULE7 RULE8 RULE20
    // Once-per-period pulse timing
    if (st_q.per >= 32'(PERIOD_CYC - 1)) begin
      st_d.per = 32'h0000_0000;
    end else begin
      st_d.per = st_q.per + 32'h0000_0001;
    end
    st_d.blink = (st_q.per < 32'(PERIOD_CYC / 2));
    case (st_q.phase)
      PH_RUN: begin
        if (st_q.per >= 32'(PERIOD_CYC - 1)) begin
          st_d.phase = PH_PULSE; // RULE1
        end
      end
      PH_PULSE: begin
        if (st_q.per >= 32'(PULSE_CYC - 1)) begin
          st_d.phase = PH_RUN; // RULE1
        end
      end
      default: begin
        st_d.phase = PH_RUN;
      end
    endcase
    // Drive: command, inverted during pulse in full groups, forced off on a short or on an open in a full group
    st_d.drive = drive_nx;
    // Settle counter restarts on every drive change
    if (st_d.drive != st_q.drive) begin
      st_d.stab = 16'h0000;
    end else if (!valid) begin
      st_d.stab = st_q.stab + 16'h0001;
    end
    // Bit-mapped status read: 1..16 open, 17..32 short
    st_d.rd_bit = 1'b0;
    if (req.rd_bit_addr < `OFM_BIT_SHORT_BASE) begin
      st_d.rd_bit = st_q.open_f[4'(15 - req.rd_bit_addr[3:0])]; // RULE4
    end else begin
      st_d.rd_bit = st_q.short_f[4'(15 - req.rd_bit_addr[3:0])];
    end
  end

  // State register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q.s1 <= '0;
      st_q.s2 <= '0;
      st_q.s3 <= '0;
      st_q.filt <= '0;
      st_q.cmd <= `OFM_RST_WORD;
      st_q.open_f <= `OFM_RST_WORD;
      st_q.short_f <= `OFM_RST_WORD;
      st_q.drive <= `OFM_RST_WORD;
      st_q.per <= 32'h0000_0000;
      st_q.stab <= 16'h0000;
      st_q.phase <= PH_RUN;
      st_q.blink <= 1'b0;
      st_q.rd_bit <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs from flops
  assign pt_out = st_q.drive;
  assign rsp.open_word = st_q.open_f; // RULE6
  assign rsp.short_word = st_q.short_f; // RULE7
  assign rsp.rd_bit = st_q.rd_bit;

  // Group fault lamps blink at the period rate
  genvar lg;
  generate
    for (lg = 0; lg < NG; lg++) begin : g_lamp
      localparam int LO = lg * `OFM_GROUP_SIZE;
      assign lamp[lg] = st_q.blink &&
        (|(st_q.open_f[LO +: `OFM_GROUP_SIZE] | st_q.short_f[LO +: `OFM_GROUP_SIZE])); // RULE16
    end
  endgenerate

endmodule // output_fault_monitor
`default_nettype wire

/* File: test/ofm_properties.sv */
// Port assertions for the output fault monitor.
// Assumes ofm_pkg is compiled first; bound to the block below.
`timescale 1ns/10ps
`default_nettype none
module ofm_properties #(
  parameter int PULSE_CYC = 100,
  parameter int PERIOD_CYC = 400,
  parameter int SETTLE_CYC = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Configuration and bus
  input wire logic map_word,
  input wire logic fmt_bcd,
  input wire ofm_pkg::io_req_t req,
  input wire ofm_pkg::io_rsp_t rsp,
  // Field side
  input wire ofm_pkg::field_in_t field,
  input wire logic [15:0] pt_out,
  input wire logic [1:0] lamp
);
  import ofm_pkg::*;
  localparam int PER = PERIOD_CYC;
  // Group fault flags and test mode masks
  wire logic [1:0] flt = {|(rsp.open_word[15:8] | rsp.short_word[15:8]),
    |(rsp.open_word[7:0] | rsp.short_word[7:0])};
  wire logic [15:0] full = {{8{field.pulse_sw[1]}}, {8{field.pulse_sw[0]}}};
  wire logic part = field.pulse_sw == 2'h0;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Outputs against writes, faults and modes
  reset_clear_a: assert property ($past(rst) |-> pt_out == 0 && rsp == 0 && lamp == 0)
    else $error("outputs not clear after reset");
  cmd_write_a: assert property (req.wr_word && map_word && !req.word_sel
    && !fmt_bcd && part && $past(part, 4)
    |-> ##2 ((pt_out ^ $past(req.wdata, 2)) & ~rsp.short_word) == 0)
    else $error("command word not driven");
  short_off_a: assert property ((rsp.short_word & $past(rsp.short_word) & pt_out) == 0)
    else $error("shorted point still driven");
  open_partial_a: assert property (part && $past(part, 4)
    |-> (rsp.open_word & ~$past(rsp.open_word) & $past(pt_out)) == 0)
    else $error("open reported while on");
  short_partial_a: assert property (part && $past(part, 4)
    |-> (rsp.short_word & ~$past(rsp.short_word) & ~$past(pt_out)) == 0)
    else $error("short reported while off");
  full_open_a: assert property ($past(field.pulse_sw, 5) == field.pulse_sw
    |-> (rsp.open_word & $past(rsp.open_word) & pt_out & full) == 0)
    else $error("open point still driven");
  lamp_dark_a: assert property (!flt[0] [*2] |-> !lamp[0])
    else $error("lamp lit without fault");
  lamp_blink_a: assert property (flt[0] && !lamp[0] |-> ##[1:PER] (lamp[0] || !flt[0]))
    else $error("lamp not blinking");
endmodule // ofm_properties
bind output_fault_monitor ofm_properties #(.PULSE_CYC(PULSE_CYC), .PERIOD_CYC(PERIOD_CYC),
  .SETTLE_CYC(SETTLE_CYC)) prop_u (.mclk(mclk), .rst(rst), .map_word(map_word),
  .fmt_bcd(fmt_bcd), .req(req), .rsp(rsp), .field(field), .pt_out(pt_out), .lamp(lamp));
`default_nettype wire

/* File: test/field_load.sv */
// Field loads of the sixteen points with open and short injection.
// Assumes the bench sets the fault masks and the group switches.
`timescale 1ns/10ps
`default_nettype none
module field_load (
  // Drive and injected faults
  input wire logic [15:0] pt_out,
  input wire logic [15:0] om,
  input wire logic [15:0] sm,
  input wire logic [1:0] sw,
  // Sense lines to the block
  output var ofm_pkg::field_in_t field
);
  import ofm_pkg::*;
  // Opens sense in both states; a short draws current only when on
  assign field = '{pulse_sw: sw, short_det: sm & pt_out, open_det: om};
endmodule // field_load
`default_nettype wire

/* File: test/testbench.sv */
// Self-checking bench for the output fault monitor.
// Assumes ofm_pkg, the block, field_load and the checker are compiled.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import ofm_pkg::*;
  localparam int PER = 400;
  localparam int PUL = 100;
  logic mclk, rst, map_word, fmt_bcd;
  logic [15:0] pt_out, om, sm, w, cmd;
  logic [1:0] lamp, sw;
  io_req_t req;
  io_rsp_t rsp;
  field_in_t field;
  int n_errors, checks_done, cyc, seed, n, i;
  output_fault_monitor #(.PULSE_CYC(PUL), .PERIOD_CYC(PER), .SETTLE_CYC(8)) dut_u (
    .mclk(mclk), .rst(rst), .map_word(map_word), .fmt_bcd(fmt_bcd), .req(req),
    .rsp(rsp), .field(field), .pt_out(pt_out), .lamp(lamp));
  field_load load_u (.pt_out(pt_out), .om(om), .sm(sm), .sw(sw), .field(field));
  // Clock
  initial begin
    mclk = 1'h0;
    forever #4 mclk = ~mclk;
  end
  // Cycle ceiling
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 10000) begin
      n_errors++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  task automatic tend(input string s);
    $display("%s test ended", s);
  endtask
  // Word write; the model keeps the accepted command
  task automatic wr(input logic sel, input logic [15:0] d);
    @(posedge mclk);
    {req.wr_word, req.word_sel, req.wdata} <= {1'h1, sel, d};
    if (map_word && !sel)
      cmd = d;
    @(posedge mclk);
    req.wr_word <= 1'h0;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  // Bit write; address k drives word bit 15-k
  task automatic wb(input logic [4:0] a, input logic v);
    @(posedge mclk);
    {req.wr_bit, req.bit_addr, req.bit_val} <= {1'h1, a, v};
    if (!map_word && !a[4])
      cmd[15 - a[3:0]] = v;
    @(posedge mclk);
    req.wr_bit <= 1'h0;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  // Mapping, partial mode faults, full mode pulses and faults
  initial begin
    seed = 32'hb418;
    {map_word, fmt_bcd, req, om, sm, sw} = '0;
    rst = 1'h1;
    repeat (16) @(posedge mclk);
    {rst, map_word} <= 2'h1;
    for (i = 0; i < 4; i++) begin
      w = 16'($random(seed));
      wr(1'h0, w);
      chk(pt_out, cmd);
      wr(1'h1, ~w);
      chk(pt_out, cmd);
    end
    @(posedge mclk) fmt_bcd <= 1'h1;
    wr(1'h0, 16'h0123);
    cmd = 16'h007b;
    chk(pt_out, cmd);
    @(posedge mclk) {fmt_bcd, map_word} <= 2'h0;
    wr(1'h0, 16'hffff);
    for (i = 0; i < 32; i++)
      wb(5'(i), i[4] | i[0]);
    chk(pt_out, cmd);
    tend("mapping");
    @(posedge mclk) {sm, req.rd_bit_addr} <= {16'h0001, 6'h1f};
    repeat (30) @(posedge mclk);
    #1;
    chk(rsp.short_word, 16'h0001);
    chk(pt_out, cmd & 16'hfffe);
    chk(16'(rsp.rd_bit), 16'h0001);
    n = 0;
    repeat (PER) @(negedge mclk) n += lamp[0] + 1000 * lamp[1];
    chk(16'(n), 16'(PER / 2));
    @(posedge mclk) sm <= 16'h0000;
    wb(5'h0f, 1'h0);
    chk(rsp.short_word, 16'h0000);
    chk(pt_out, cmd);
    @(posedge mclk) om <= 16'h0004;
    repeat (30) @(posedge mclk);
    #1;
    chk(rsp.open_word, 16'h0000);
    wb(5'h0d, 1'h0);
    repeat (20) @(posedge mclk);
    #1;
    chk(rsp.open_word, 16'h0004);
    wb(5'h0d, 1'h1);
    chk(rsp.open_word, 16'h0000);
    chk(pt_out, cmd);
    tend("partial");
    @(posedge mclk) {om, sw} <= {16'h0000, 2'h1};
    repeat (PER) @(posedge mclk);
    n = 0;
    repeat (PER) @(negedge mclk) n += pt_out[0] + 1000 * !pt_out[8];
    chk(16'(n), 16'(PUL));
    chk(rsp.open_word | rsp.short_word, 16'h0000);
    @(posedge mclk) om <= 16'h0004;
    repeat (PER) @(posedge mclk);
    #1;
    chk(rsp.open_word, 16'h0004);
    chk(pt_out & 16'h0004, 16'h0000);
    @(posedge mclk) om <= 16'h0000;
    repeat (6) @(posedge mclk);
    wb(5'h0d, 1'h0);
    chk(rsp.open_word, 16'h0000);
    @(posedge mclk) sm <= 16'h0001;
    repeat (PER + 20) @(posedge mclk);
    #1;
    chk(rsp.short_word, 16'h0001);
    tend("full");
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
